//--- rds_air_model.sv
// air-side bit source for both channels, index 0 is A and 1 is B
`timescale 1ns/10ps
module rds_air_model (
  // clock
  input  wire logic       clk_i,
  // bit lines
  output logic [1:0]      tick_o,
  output logic [1:0]      bit_o,
  output logic [1:0]      val_o
);
  initial begin
    tick_o = 2'b00;
    bit_o  = 2'b00;
    val_o  = 2'b00;
  end

  // one bit a tick, back to back; first air bit is data bit 0
  task automatic send(input int ch, input logic [7:0] d, input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      #1;
      tick_o[ch] = 1'b1;
      bit_o[ch]  = d[i];
      val_o[ch]  = m[i];
    end
    @(posedge clk_i);
    #1;
    tick_o[ch] = 1'b0;
    // idle line keeps the inverse of the last bit, valid dropped
    bit_o[ch]  = ~bit_o[ch];
    val_o[ch]  = 1'b0;
  endtask
endmodule

//--- rds_bit_asm.sv
// bit-to-byte assembler with end-of-frame gap detection, one per channel
`timescale 1ns/10ps
module rds_bit_asm import rds_pkg::*; (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // control
  input  wire logic        enable_i,
  input  wire logic [7:0]  eof_len_i,
  // air side, one bit per tick
  input  wire logic        tick_i,
  input  wire logic        bit_i,
  input  wire logic        bit_valid_i,
  // assembled output
  output logic [7:0]       byte_o,
  output logic [7:0]       mask_o,
  output logic             load_o,
  output logic             eof_o
);
  rds_asm_state_e state;
  rds_asm_state_e next_state;
  logic [7:0]     shift;
  logic [7:0]     qual;
  logic [2:0]     pos;
  logic [7:0]     gap;
  logic [7:0]     next_shift;
  logic [7:0]     next_qual;
  logic [2:0]     next_pos;
  logic [7:0]     next_gap;
  logic           next_load;
  logic           next_eof;
  logic [7:0]     next_byte;
  logic [7:0]     next_mask;

  always_comb begin
    next_state = state;
    next_shift = shift;
    next_qual  = qual;
    next_pos   = pos;
    next_gap   = gap;
    next_load  = 1'b0;
    next_eof   = 1'b0;
    next_byte  = byte_o;
    next_mask  = mask_o;
    case (state)
      RDS_ASM_IDLE: begin
        if (enable_i && tick_i && bit_valid_i) begin
          next_state   = RDS_ASM_RECV;
          next_shift   = {7'h00, bit_i};
          next_qual    = 8'h01;
          next_pos     = 3'h1;
          next_gap     = 8'h00;
        end
      end
      RDS_ASM_RECV: begin
        if (!enable_i) begin
          next_state = RDS_ASM_IDLE;
        end else if (tick_i) begin
          // first bit on air lands in bit 0
          next_shift[pos] = bit_i & bit_valid_i; // see RULE7 see RULE10
          next_qual[pos]  = bit_valid_i; // see RULE8
          next_pos        = pos + 3'h1;
          next_gap        = bit_valid_i ? 8'h00 : gap + 8'h01;
          if (!bit_valid_i && (gap + 8'h01) >= eof_len_i) begin
            // gap long enough: frame ends, partial byte flushed
            next_eof   = 1'b1; // see RULE1
            next_state = RDS_ASM_IDLE;
            next_load  = qual != 8'h00; // see RULE12
            next_byte  = shift;
            next_mask  = qual;
          end else if (pos == RDS_LAST_POS) begin
            next_load  = 1'b1;
            next_byte  = next_shift;
            next_mask  = next_qual;
          end
          if (next_load) begin
            next_shift = 8'h00;
            next_qual  = 8'h00;
            next_pos   = 3'h0;
          end
        end
      end
      default: begin
        next_state = RDS_ASM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state  <= RDS_ASM_IDLE;
      shift  <= RDS_RST_BYTE;
      qual   <= RDS_RST_QUAL;
      pos    <= 3'h0;
      gap    <= 8'h00;
      load_o <= 1'b0;
      eof_o  <= 1'b0;
      byte_o <= RDS_RST_BYTE;
      mask_o <= RDS_RST_QUAL;
    end else begin
      state  <= next_state;
      shift  <= next_shift;
      qual   <= next_qual;
      pos    <= next_pos;
      gap    <= next_gap;
      load_o <= next_load;
      eof_o  <= next_eof;
      byte_o <= next_byte;
      mask_o <= next_mask;
    end
  end
endmodule

//--- rds_fifo.sv
// parameterised first-in first-out word buffer
`timescale 1ns/10ps
module rds_fifo import rds_pkg::*; #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_b_i,
  // fill side
  rds_stream_if.snk   push,
  // drain side
  rds_stream_if.src   pop
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic [AW:0]  next_wr_ptr;
  logic [AW:0]  next_rd_ptr;
  logic         do_push;
  logic         do_pop;

  assign push.ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign pop.valid  = wr_ptr != rd_ptr;
  assign pop.data   = mem[rd_ptr[AW-1:0]];
  assign do_push    = push.valid & push.ready;
  assign do_pop     = pop.valid & pop.ready;

  always_comb begin
    next_wr_ptr = do_push ? wr_ptr + (AW+1)'(1) : wr_ptr;
    next_rd_ptr = do_pop ? rd_ptr + (AW+1)'(1) : rd_ptr;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // storage carries no reset; only written words are ever read
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr[AW-1:0]] <= push.data;
    end
  end
endmodule

//--- rds_pkg.sv
// shared constants and types of the receive deserializer status block
package rds_pkg;

  // register offsets
  localparam logic [7:0] RDS_OFS_EVENT_FLAGS = 8'h08;
  localparam logic [7:0] RDS_OFS_BYTE_A      = 8'h09;
  localparam logic [7:0] RDS_OFS_QUAL_A      = 8'h0a;
  localparam logic [7:0] RDS_OFS_BYTE_B      = 8'h0b;

  // field positions in receive_event_flags
  localparam int RDS_BIT_FULL_A  = 0;
  localparam int RDS_BIT_EOF_A   = 1;
  localparam int RDS_BIT_FLOW_A  = 2;
  localparam int RDS_BIT_VALID_A = 3;

  // reset values and the all-valid qualifier pattern
  localparam logic [7:0] RDS_RST_BYTE  = 8'h00;
  localparam logic [7:0] RDS_RST_QUAL  = 8'h00;
  localparam logic [7:0] RDS_RST_FLAGS = 8'h00;
  localparam logic [7:0] RDS_ALL_VALID = 8'hff;

  // sizes
  localparam int RDS_BYTE_W     = 8;
  localparam int RDS_FIFO_W     = 16;
  localparam int RDS_FIFO_DEPTH = 16;
  localparam logic [2:0] RDS_LAST_POS = 3'h7;

  typedef enum logic [1:0] {
    RDS_ASM_IDLE = 2'b01,
    RDS_ASM_RECV = 2'b10
  } rds_asm_state_e;

endpackage

//--- rds_rx_status.sv
// receive result registers of the two-channel deserializer
// Function
// RULE1: once channel A reception has begun, the end-of-frame flag rises after the programmed number of bit times pass without a valid bit.
// RULE2: the channel A end-of-frame flag is bit 1 of the receive status register, one meaning pending.
// RULE3: reading the receive status register clears the channel A end-of-frame flag; here only a read in receive mode clears it.
// RULE4: flags are set and readable regardless of any interrupt enable, so polling works.
// RULE5: receive status reads as zero whenever the device is not in receive mode.
// RULE6: the status registers are read-only and host writes change no flag.
// RULE7: the channel A byte is assembled first air bit into bit 0, last into bit 7, and is read-only.
// RULE8: each channel A qualifier bit is one exactly when the same data bit holds a valid received bit.
// RULE9: with the all-valid flag set all eight channel A data bits are valid, so the host may skip the qualifier register.
// RULE10: the channel B byte is assembled in air order from bit 0 up to bit 7 and is read-only.
// RULE11: overflow is flagged when a new byte arrives before the previous is read, underflow when an empty data register is read;
// here both are flagged for channel A only, overflow only when a byte meets the full 16-word queue.
// RULE12: the buffer-full flag is set on every transfer into the data register, full byte or partial byte at end of frame.
// RULE13: on each data register write the all-valid flag is set only if every bit is valid, and it never interrupts.
// RULE14: the flow-violation and buffer-full flags are also cleared by a read of the receive status register; here only a read in receive mode clears them.
`timescale 1ns/10ps
module rds_rx_status import rds_pkg::*; (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // mode and frame setup
  input  wire logic        rx_en_i,
  input  wire logic        tx_en_i,
  input  wire logic [7:0]  eof_len_i,
  // channel A air side
  input  wire logic        a_tick_i,
  input  wire logic        a_bit_i,
  input  wire logic        a_bit_valid_i,
  // channel B air side
  input  wire logic        b_tick_i,
  input  wire logic        b_bit_i,
  input  wire logic        b_bit_valid_i,
  // register read port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o,
  output logic             reg_rvalid_o,
  // buffer state
  output logic             a_buf_ready_o
);

  logic       rx_mode;
  logic [7:0] a_asm_byte;
  logic [7:0] a_asm_mask;
  logic       a_asm_load;
  logic       a_asm_eof;
  logic [7:0] b_asm_byte;
  logic [7:0] b_asm_mask;
  logic       b_asm_load;
  logic       b_asm_eof;

  // register state
  logic [7:0] byte_a;
  logic [7:0] qual_a;
  logic [7:0] byte_b;
  logic       a_loaded;
  logic       flag_full_a;
  logic       flag_eof_a;
  logic       flag_flow_a;
  logic       flag_valid_a;
  logic [7:0] rdata;
  logic       rvalid;

  logic [7:0] next_byte_a;
  logic [7:0] next_qual_a;
  logic [7:0] next_byte_b;
  logic       next_a_loaded;
  logic       next_flag_full_a;
  logic       next_flag_eof_a;
  logic       next_flag_flow_a;
  logic       next_flag_valid_a;
  logic [7:0] next_rdata;
  logic       next_rvalid;

  // decoded accesses
  logic       rd_flags;
  logic       rd_byte_a;
  logic       rd_byte_b;
  logic       rd_qual_a;
  logic       a_transfer;
  logic       a_overflow;
  logic       a_underflow;
  logic [7:0] flags_live;

  rds_stream_if #(.W(RDS_FIFO_W)) a_push ();
  rds_stream_if #(.W(RDS_FIFO_W)) a_pop ();

  // transmit enable wins: the part is in receive mode only with rx alone
  assign rx_mode = rx_en_i & ~tx_en_i;

  rds_bit_asm u_asm_a (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .enable_i    (rx_mode),
    .eof_len_i   (eof_len_i),
    .tick_i      (a_tick_i),
    .bit_i       (a_bit_i),
    .bit_valid_i (a_bit_valid_i),
    .byte_o      (a_asm_byte),
    .mask_o      (a_asm_mask),
    .load_o      (a_asm_load),
    .eof_o       (a_asm_eof)
  );

  rds_bit_asm u_asm_b (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .enable_i    (rx_mode),
    .eof_len_i   (eof_len_i),
    .tick_i      (b_tick_i),
    .bit_i       (b_bit_i),
    .bit_valid_i (b_bit_valid_i),
    .byte_o      (b_asm_byte),
    .mask_o      (b_asm_mask),
    .load_o      (b_asm_load),
    .eof_o       (b_asm_eof)
  );

  // channel A bytes queue up while the host has not fetched the last one
  assign a_push.valid = a_asm_load;
  assign a_push.data  = {a_asm_mask, a_asm_byte};

  rds_fifo #(
    .W     (RDS_FIFO_W),
    .DEPTH (RDS_FIFO_DEPTH)
  ) u_fifo_a (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .push    (a_push),
    .pop     (a_pop)
  );

  assign a_buf_ready_o = a_push.ready;

  // drain one word into the data register only once the host emptied it
  assign a_pop.ready = ~a_loaded | rd_byte_a;
  assign a_transfer  = a_pop.valid & a_pop.ready;

  // register port decode; nothing here is writable
  assign rd_flags  = reg_rd_i && (reg_addr_i == RDS_OFS_EVENT_FLAGS); // see RULE6
  assign rd_byte_a = reg_rd_i && (reg_addr_i == RDS_OFS_BYTE_A);
  assign rd_qual_a = reg_rd_i && (reg_addr_i == RDS_OFS_QUAL_A);
  assign rd_byte_b = reg_rd_i && (reg_addr_i == RDS_OFS_BYTE_B);

  // the radio cannot be stalled: a byte meeting a full queue is lost
  assign a_overflow  = a_push.valid & ~a_push.ready; // see RULE11
  assign a_underflow = rd_byte_a & ~a_loaded; // see RULE11

  always_comb begin
    flags_live = RDS_RST_FLAGS;
    flags_live[RDS_BIT_FULL_A]  = flag_full_a;
    flags_live[RDS_BIT_EOF_A]   = flag_eof_a; // see RULE2
    flags_live[RDS_BIT_FLOW_A]  = flag_flow_a;
    flags_live[RDS_BIT_VALID_A] = flag_valid_a;
  end

  // data and qualifier registers
  always_comb begin
    next_byte_a   = byte_a;
    next_qual_a   = qual_a;
    next_byte_b   = byte_b;
    next_a_loaded = a_loaded;
    if (rd_byte_a) begin
      next_a_loaded = 1'b0;
    end
    if (a_transfer) begin
      next_byte_a   = a_pop.data[7:0]; // see RULE7
      next_qual_a   = a_pop.data[15:8]; // see RULE8
      next_a_loaded = 1'b1;
    end
    if (b_asm_load) begin
      next_byte_b = b_asm_byte; // see RULE10
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      byte_a   <= RDS_RST_BYTE;
      qual_a   <= RDS_RST_QUAL;
      byte_b   <= RDS_RST_BYTE;
      a_loaded <= 1'b0;
    end else begin
      byte_a   <= next_byte_a;
      qual_a   <= next_qual_a;
      byte_b   <= next_byte_b;
      a_loaded <= next_a_loaded;
    end
  end

  // event flags: set beats the clearing read in the same cycle;
  // no interrupt enable takes part, so polling sees every event
  always_comb begin
    next_flag_full_a  = flag_full_a;
    next_flag_eof_a   = flag_eof_a;
    next_flag_flow_a  = flag_flow_a;
    next_flag_valid_a = flag_valid_a;
    // a masked read returns zero, so it must not consume hidden events
    if (rd_flags && rx_mode) begin
      next_flag_eof_a  = 1'b0; // see RULE3
      next_flag_full_a = 1'b0; // see RULE14
      next_flag_flow_a = 1'b0; // see RULE14
    end
    if (a_asm_eof) begin
      next_flag_eof_a = 1'b1; // see RULE1 see RULE4
    end
    if (a_transfer) begin
      next_flag_full_a  = 1'b1; // see RULE12 see RULE4
      next_flag_valid_a = a_pop.data[15:8] == RDS_ALL_VALID; // see RULE13 see RULE9
    end
    if (a_overflow || a_underflow) begin
      next_flag_flow_a = 1'b1; // see RULE11 see RULE4
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      flag_full_a  <= 1'b0;
      flag_eof_a   <= 1'b0;
      flag_flow_a  <= 1'b0;
      flag_valid_a <= 1'b0;
    end else begin
      flag_full_a  <= next_flag_full_a;
      flag_eof_a   <= next_flag_eof_a;
      flag_flow_a  <= next_flag_flow_a;
      flag_valid_a <= next_flag_valid_a;
    end
  end

  // read data, one cycle after the strobe; unmapped offsets return zero
  always_comb begin
    next_rdata  = RDS_RST_FLAGS;
    next_rvalid = reg_rd_i;
    if (rd_flags) begin
      next_rdata = rx_mode ? flags_live : RDS_RST_FLAGS; // see RULE5
    end else if (rd_byte_a) begin
      next_rdata = byte_a;
    end else if (rd_qual_a) begin
      next_rdata = qual_a;
    end else if (rd_byte_b) begin
      next_rdata = byte_b;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata  <= RDS_RST_FLAGS;
      rvalid <= 1'b0;
    end else begin
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign reg_rdata_o  = rdata;
  assign reg_rvalid_o = rvalid;

endmodule

//--- rds_rx_status_assertions.sv
// concurrent checks on the receive status block ports
`timescale 1ns/10ps
module rds_rx_status_assertions import rds_pkg::*; (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // mode and channel A
  input  wire logic       rx_en_i,
  input  wire logic       tx_en_i,
  input  wire logic       a_tick_i,
  // register port and buffer state
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_rdata_o,
  input  wire logic       reg_rvalid_o,
  input  wire logic       a_buf_ready_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  logic [3:0] quiet;
  logic [3:0] next_quiet;
  logic       rxm;
  logic       rd_stat;

  // cycles since the last channel A tick, so pending events have landed
  always_comb begin
    next_quiet = quiet;
    if (a_tick_i) begin
      next_quiet = 4'h0;
    end else if (quiet != 4'hf) begin
      next_quiet = quiet + 4'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    quiet <= rst_b_i ? next_quiet : 4'h0;
  end
  assign rxm     = rx_en_i & ~tx_en_i;
  assign rd_stat = reg_rd_i && reg_addr_i == RDS_OFS_EVENT_FLAGS;

  AST_RVALID_LAT: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read strobe not answered next cycle");
  AST_RVALID_SPUR: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("read answer without strobe");
  AST_RDATA_IDLE: assert property (!reg_rvalid_o |-> reg_rdata_o == 8'h00)
    else $error("read data not zero while idle");
  AST_UNMAPPED: assert property (reg_rd_i && (reg_addr_i < 8'h08 || reg_addr_i > 8'h0b)
    |=> reg_rdata_o == 8'h00) else $error("unmapped offset not zero");
  AST_NORX_ZERO: assert property (rd_stat && !rxm |=> reg_rdata_o == 8'h00)
    else $error("status not zero outside receive mode");
  AST_STAT_HIGH: assert property (rd_stat |=> reg_rdata_o[7:4] == 4'h0)
    else $error("status upper bits not zero");
  // both reads far from any channel A tick, so no late event lands between them
  AST_READ_CLEARS: assert property (rd_stat && rxm && quiet > 4'h5 ##1 !reg_rd_i
    ##1 rd_stat && rxm && quiet > 4'h5 |=> reg_rdata_o[2:0] == 3'h0)
    else $error("status read left flags");
  AST_RESET_STATE: assert property ($rose(rst_b_i) |-> a_buf_ready_o && !reg_rvalid_o)
    else $error("state after reset wrong");

  COV_STAT: cover property (rd_stat && rxm);
  COV_FULL: cover property (!a_buf_ready_o);
  COV_EOF: cover property (reg_rvalid_o && reg_rdata_o[RDS_BIT_EOF_A]);
endmodule

bind rds_rx_status rds_rx_status_assertions u_rds_rx_status_assertions (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .rx_en_i(rx_en_i), .tx_en_i(tx_en_i),
  .a_tick_i(a_tick_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .a_buf_ready_o(a_buf_ready_o)
);

//--- rds_stream_if.sv
// valid/ready word stream between the block's own modules
`timescale 1ns/10ps
interface rds_stream_if #(
  parameter int W = 16
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- tb_rds_rx_status.sv
// self-checking bench for the receive status block
`timescale 1ns/10ps
module tb_rds_rx_status import rds_pkg::*;;
  logic       clk;
  logic       rst_b;
  logic       rx_en;
  logic       tx_en;
  logic [7:0] eof_len;
  logic [1:0] tick;
  logic [1:0] bitv;
  logic [1:0] val;
  logic [7:0] addr;
  logic       rd;
  logic [7:0] rdata;
  logic       rvalid;
  logic       buf_ready;
  int         mismatches;
  int         num_checks;

  rds_rx_status u_rds_rx_status (
    .clk_i(clk), .rst_b_i(rst_b), .rx_en_i(rx_en), .tx_en_i(tx_en),
    .eof_len_i(eof_len), .a_tick_i(tick[0]), .a_bit_i(bitv[0]),
    .a_bit_valid_i(val[0]), .b_tick_i(tick[1]), .b_bit_i(bitv[1]),
    .b_bit_valid_i(val[1]), .reg_addr_i(addr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .a_buf_ready_o(buf_ready)
  );
  rds_air_model u_rds_air_model (.clk_i(clk), .tick_o(tick), .bit_o(bitv), .val_o(val));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle strobe, answer sampled in the cycle after it
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input bit care = 1'b1);
    @(posedge clk);
    #1;
    rd   = 1'b1;
    addr = a;
    @(posedge clk);
    #1;
    rd = 1'b0;
    if (care) begin
      chk(rvalid ? rdata : 8'hxx, exp, $sformatf("reg %h", a));
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // whole run is a few hundred cycles
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end

  initial begin
    rst_b      = 1'b0;
    rx_en      = 1'b1;
    tx_en      = 1'b0;
    eof_len    = 8'h03;
    addr       = 8'h00;
    rd         = 1'b0;
    mismatches = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    // reset contents, then one unmapped offset
    for (int i = 8; i < 13; i++) begin
      rdc(8'(i), 8'h00);
    end
    // the read of the still empty data register above is an underflow
    rdc(RDS_OFS_EVENT_FLAGS, 8'h04);
    u_rds_air_model.send(0, 8'ha5, 8'hff, 8);
    idle(6);
    rdc(RDS_OFS_EVENT_FLAGS, 8'h09);
    rdc(RDS_OFS_EVENT_FLAGS, 8'h08);
    rdc(RDS_OFS_BYTE_A, 8'ha5);
    rdc(RDS_OFS_QUAL_A, 8'hff);
    rdc(RDS_OFS_BYTE_A, 8'h00, 1'b0);
    rdc(RDS_OFS_EVENT_FLAGS, 8'h0c);
    // flags hidden, not lost, outside receive mode
    u_rds_air_model.send(0, 8'h3c, 8'hff, 8);
    idle(6);
    #1;
    tx_en = 1'b1;
    rdc(RDS_OFS_EVENT_FLAGS, 8'h00);
    tx_en = 1'b0;
    rx_en = 1'b0;
    rdc(RDS_OFS_EVENT_FLAGS, 8'h00);
    rx_en = 1'b1;
    rdc(RDS_OFS_EVENT_FLAGS, 8'h09);
    rdc(RDS_OFS_BYTE_A, 8'h3c);
    // partial byte closed by three invalid bit times
    u_rds_air_model.send(0, 8'h05, 8'h07, 6);
    idle(6);
    rdc(RDS_OFS_EVENT_FLAGS, 8'h03);
    rdc(RDS_OFS_EVENT_FLAGS, 8'h00);
    rdc(RDS_OFS_BYTE_A, 8'h05);
    rdc(RDS_OFS_QUAL_A, 8'h07);
    u_rds_air_model.send(1, 8'h96, 8'hff, 8);
    idle(4);
    rdc(RDS_OFS_BYTE_B, 8'h96);
    rdc(RDS_OFS_EVENT_FLAGS, 8'h00);
    // data register plus 16 queued words, the eighteenth byte is lost
    for (int i = 0; i < 18; i++) begin
      u_rds_air_model.send(0, 8'(i), 8'hff, 8);
    end
    idle(6);
    #1;
    chk({7'h00, buf_ready}, 8'h00, "buffer ready");
    rdc(RDS_OFS_EVENT_FLAGS, 8'h0d);
    for (int i = 0; i < 17; i++) begin
      rdc(RDS_OFS_BYTE_A, 8'(i));
      idle(3);
    end
    rdc(RDS_OFS_EVENT_FLAGS, 8'h09);
    give_verdict();
  end
endmodule
